// *** src/cap_touch_status_irq.sv ***
// Matrix discharge timing, status flags and interrupt mask of the touch
// module, with an AXI4-Lite register slave. Assumes prescale_tick and the
// event inputs come from logic on aclk; comparator_in is asynchronous.
// Operation
// - Comparator gating bit one lets comparators sleep when idle; zero keeps them on.
// - Nonzero consensus N ends discharge once N of last 5 samples positive.
// - Consensus zero ends discharge as soon as comparator reads positive.
// - After each burst cycle, discharge Cx for the programmed prescaler tick count; the code skips it unless the engine is idle with no discharge request.
// - Nonzero interval spaces X-line starts by that many prescaled ticks.
// - Acquisition-done reads zero while running, one once complete.
// - Count-ready reads one while an acquired count is available.
// - Burst-length-request reads one when the current X line needs lengths.
// - Autonomous-active bit follows the autonomous sensor state.
// - Autonomous status change sets a sticky flag.
// - Calibrating flag is set while the autonomous sensor calibrates and stays set until cleared.
// - Module-enabled bit reads one when the touch module is enabled.
// - Writing one to status clear clears that flag and request; zeros ignored. The code clears sticky flags only; the burst-length request is a live level.
// - Writing one to enable-set sets the matching mask bit.
// - Writing one to enable-clear clears the matching mask bit.
// - Mask one enables its interrupt; all mask bits zero after reset.
// - Burst-length request stays high while waiting for burst lengths.
`timescale 1ns/10ps
`include "cap_touch_consts.svh"
`default_nettype none

module cap_touch_status_irq #(
  parameter int ADDR_W = 8 // Byte address width, at least 8
)
(
  input wire logic aclk, // Module clock, 100 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response code
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response code
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic prescale_tick, // Pulse per burst prescaler clock
  input wire logic comparator_in, // Raw comparator output
  input wire logic discharge_start, // Pulse: begin matrix discharge
  input wire logic burst_cycle_end, // Pulse: a burst cycle ended
  input wire logic xline_request, // Pulse: next X line is ready
  input wire cap_touch_pkg::acq_events_type acq_events, // Sequencer events
  input wire cap_touch_pkg::sense_state_type sense_state, // Module levels
  output logic comparator_enable, // High: comparators powered
  output logic discharge_done, // Pulse: matrix discharge ended
  output logic cx_discharge, // High: Cx discharge in progress
  output logic xline_start, // Pulse: start acquisition on next X line
  output logic irq // Level interrupt, active high
);

  // Address match on word boundaries; shared by read and write decode
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
  endfunction : addr_is

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // Number of positive samples held in the consensus history
  function automatic logic [2:0] ones(input logic [`HIST_LEN-1:0] h);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `HIST_LEN; i++)
    begin
      n = n + {2'b00, h[i]};
    end
    ones = n;
  endfunction : ones

  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic [31:0] cfg_reg, cfg_next;
  logic [31:0] sticky_reg, sticky_next;
  logic [31:0] mask_reg, mask_next;
  logic irq_reg;
  cap_touch_pkg::sense_state_type sense_reg;
  cap_touch_pkg::matrix_cfg_two_type cfg_view;

  logic cmp_s1_reg, cmp_s2_reg, cmp_s3_reg, cmp_level_reg;
  logic [`HIST_LEN-1:0] hist_reg, hist_next;
  cap_touch_pkg::engine_state_type state_reg, state_next;
  logic [7:0] cx_cnt_reg, cx_cnt_next;
  logic cx_discharge_reg, discharge_done_reg, cmp_en_reg;
  logic [11:0] sync_cnt_reg, sync_cnt_next;
  logic pend_reg, pend_next, xline_start_reg;

  // Write channel handshakes; address and data may arrive in either order
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
  assign w_full_next = (w_full_reg | w_take) & ~do_write;
  assign bvalid_next = (bvalid_reg & ~s_axi_bready) | do_write;
  // Ready stays low while a response waits, so one write is in flight
  assign awready_next = ~aw_full_next & ~bvalid_next;
  assign wready_next = ~w_full_next & ~bvalid_next;

  // Read channel: one read in flight, answered the cycle after it is taken
  wire ar_take = s_axi_arvalid & arready_reg;
  assign rvalid_next = (rvalid_reg & ~s_axi_rready) | ar_take;
  assign arready_next = ~rvalid_next;

  // Write decode
  wire wr_cfg = do_write & addr_is(waddr_reg, `OFS_MATRIX_CFG2);
  wire wr_clr = do_write & addr_is(waddr_reg, `OFS_SCLR);
  wire wr_ien = do_write & addr_is(waddr_reg, `OFS_IEN);
  wire wr_idis = do_write & addr_is(waddr_reg, `OFS_IDIS);
  wire wr_ro = addr_is(waddr_reg, `OFS_STATUS) | addr_is(waddr_reg, `OFS_IMASK);
  wire wr_mapped = wr_cfg | wr_clr | wr_ien | wr_idis | (do_write & wr_ro);
  wire [31:0] wmask = strb_mask(wstrb_reg);
  wire [31:0] wbits = wdata_reg & wmask;

  // Configuration word with byte lanes merged; reserved bits stay zero
  assign cfg_next = wr_cfg ? (((cfg_reg & ~wmask) | wbits) & `MATRIX_CFG2_WMASK) : cfg_reg;
  assign cfg_view = cap_touch_pkg::matrix_cfg_two_type'(cfg_reg);

  // Sticky flags: events set, clear-writes and sequencer events clear
  wire status_change = sense_state.auto_active != sense_reg.auto_active;
  wire [31:0] set_vec = (32'(acq_events.complete) << `BIT_DONE)
                      | (32'(acq_events.count_avail) << `BIT_READY)
                      | (32'(status_change) << `BIT_CHANGE)
                      | (32'(sense_state.auto_calibrating) << `BIT_CAL);
  wire [31:0] clr_vec = (wr_clr ? wbits : `ZERO32)
                      | (32'(acq_events.start) << `BIT_DONE)
                      | (32'(acq_events.count_taken) << `BIT_READY);
  // A set in the clearing cycle survives, so no event is lost
  assign sticky_next = ((sticky_reg & ~clr_vec) | set_vec) & `IRQ_BITS;

  // Mask set and clear by separate one-writes
  wire [31:0] mset = wr_ien ? wbits : `ZERO32;
  wire [31:0] mclr = wr_idis ? wbits : `ZERO32;
  assign mask_next = ((mask_reg | mset) & ~mclr) & `IRQ_BITS;

  // Status word: sticky flags plus live levels
  wire [31:0] status_word = sticky_reg
                          | (32'(sense_reg.burst_len_wait) << `BIT_BLREQ)
                          | (32'(sense_reg.auto_active) << `BIT_ACTIVE)
                          | (32'(sense_reg.module_enabled) << `BIT_EN);

  // Read decode; write-only words read as zero
  wire rd_cfg = addr_is(s_axi_araddr, `OFS_MATRIX_CFG2);
  wire rd_status = addr_is(s_axi_araddr, `OFS_STATUS);
  wire rd_mask = addr_is(s_axi_araddr, `OFS_IMASK);
  wire rd_wo = addr_is(s_axi_araddr, `OFS_SCLR) | addr_is(s_axi_araddr, `OFS_IEN)
             | addr_is(s_axi_araddr, `OFS_IDIS);
  wire rd_mapped = rd_cfg | rd_status | rd_mask | rd_wo;
  wire [31:0] rd_word = rd_cfg ? cfg_reg : rd_status ? status_word : rd_mask ? mask_reg : `ZERO32;

  // Bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= `ZERO32;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `ZERO32;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take) waddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      bvalid_reg <= bvalid_next;
      if (do_write) bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) rdata_reg <= rd_word;
      if (ar_take) rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Register file and interrupt line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= `ZERO32;
      sticky_reg <= `ZERO32;
      mask_reg <= `ZERO32;
      irq_reg <= 1'b0;
      sense_reg <= '0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      sticky_reg <= sticky_next;
      mask_reg <= mask_next;
      irq_reg <= |(sticky_next & mask_next);
      sense_reg <= sense_state;
    end
  end

  // Comparator synchroniser; a level change counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      cmp_s3_reg <= 1'b0;
      cmp_level_reg <= 1'b0;
    end
    else
    begin
      cmp_s1_reg <= comparator_in;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      if (cmp_s2_reg == cmp_s3_reg) cmp_level_reg <= cmp_s3_reg;
    end
  end

  // Discharge termination; a consensus above five never ends discharge
  wire consensus_off = cfg_view.consensus_length == `CONSENSUS_OFF;
  wire consensus_met = ones(hist_reg) >= cfg_view.consensus_length;
  wire disch_end = consensus_off ? cmp_level_reg : consensus_met;
  wire [7:0] cx_len = cfg_view.sense_cap_discharge_length;
  // Taken from the register, so the next-state logic never reads its own output
  wire cx_last = prescale_tick & (8'(cx_cnt_reg + 8'h01) == cx_len);

  // Engine next state; a discharge request wins over a burst-cycle end
  always_comb
  begin
    state_next = state_reg;
    hist_next = hist_reg;
    cx_cnt_next = cx_cnt_reg;
    unique case (state_reg)
      cap_touch_pkg::ENG_IDLE:
      begin
        if (discharge_start)
        begin
          state_next = cap_touch_pkg::ENG_DISCHARGE;
          hist_next = '0; // Stale samples must not vote
        end
        else if (burst_cycle_end && cx_len != `CX_ZERO)
        begin
          state_next = cap_touch_pkg::ENG_CX_DISCHARGE;
          cx_cnt_next = `CX_ZERO;
        end
      end
      cap_touch_pkg::ENG_DISCHARGE:
      begin
        if (prescale_tick) hist_next = {hist_reg[`HIST_LEN-2:0], cmp_level_reg};
        if (disch_end) state_next = cap_touch_pkg::ENG_IDLE;
      end
      cap_touch_pkg::ENG_CX_DISCHARGE:
      begin
        if (prescale_tick) cx_cnt_next = cx_cnt_reg + 8'h01;
        if (cx_last) state_next = cap_touch_pkg::ENG_IDLE;
      end
    endcase
  end

  // X-line spacing: counter of ticks since the last start, saturating
  wire sync_off = cfg_view.xline_start_interval == `SYNC_ZERO;
  wire start_ok = pend_reg & (sync_off | sync_cnt_reg >= cfg_view.xline_start_interval);
  assign pend_next = (pend_reg & ~start_ok) | xline_request;
  assign sync_cnt_next = start_ok ? `SYNC_ZERO
                       : (prescale_tick && sync_cnt_reg != `SYNC_MAX) ? sync_cnt_reg + 12'h001
                       : sync_cnt_reg;

  // Engine registers and outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= cap_touch_pkg::ENG_IDLE;
      hist_reg <= '0;
      cx_cnt_reg <= `CX_ZERO;
      cx_discharge_reg <= 1'b0;
      discharge_done_reg <= 1'b0;
      cmp_en_reg <= 1'b1;
      sync_cnt_reg <= `SYNC_MAX; // First X line need not wait
      pend_reg <= 1'b0;
      xline_start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hist_reg <= hist_next;
      cx_cnt_reg <= cx_cnt_next;
      cx_discharge_reg <= state_next == cap_touch_pkg::ENG_CX_DISCHARGE;
      discharge_done_reg <= (state_reg == cap_touch_pkg::ENG_DISCHARGE) & disch_end;
      // Powering down only when allowed and no discharge needs the comparator
      cmp_en_reg <= ~cfg_view.comparator_gating_allow
                    | (state_next == cap_touch_pkg::ENG_DISCHARGE);
      sync_cnt_reg <= sync_cnt_next;
      pend_reg <= pend_next;
      xline_start_reg <= start_ok;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign comparator_enable = cmp_en_reg;
  assign discharge_done = discharge_done_reg;
  assign cx_discharge = cx_discharge_reg;
  assign xline_start = xline_start_reg;
  assign irq = irq_reg;

  a_gate_off_on: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_view.comparator_gating_allow |=> comparator_enable)
    else $error("comparator disabled while gating not allowed");

  a_consensus_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == cap_touch_pkg::ENG_DISCHARGE && !consensus_off && consensus_met)
    |=> discharge_done && state_reg == cap_touch_pkg::ENG_IDLE)
    else $error("discharge not ended on consensus");

  a_raw_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == cap_touch_pkg::ENG_DISCHARGE && consensus_off && !cmp_level_reg)
    |=> !discharge_done)
    else $error("discharge ended with comparator low");

  a_cx_length: assert property (@(posedge aclk) disable iff (!aresetn)
    (cx_discharge && prescale_tick && cx_cnt_reg + 8'h01 == cx_len)
    |=> !cx_discharge)
    else $error("Cx discharge overran its length");

  a_sync_space: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(xline_start) && !sync_off |-> $past(sync_cnt_reg) >= cfg_view.xline_start_interval)
    else $error("X line started too early");

  a_done_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    acq_events.start && !acq_events.complete |=> !sticky_reg[`BIT_DONE])
    else $error("done flag not cleared at acquisition start");

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_clr && wbits[`BIT_CHANGE] && status_change |=> sticky_reg[`BIT_CHANGE])
    else $error("status change lost against clear");

  a_mask_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ien |=> (mask_reg & $past(wbits) & `IRQ_BITS) == ($past(wbits) & `IRQ_BITS))
    else $error("mask bit not set");

  a_mask_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_idis |=> (mask_reg & $past(wbits)) == `ZERO32)
    else $error("mask bit not cleared");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(sticky_reg & mask_reg))
    else $error("interrupt line does not match flags and mask");

endmodule : cap_touch_status_irq

`default_nettype wire

// *** common/cap_touch_consts.svh ***
// Register offsets, field masks, bit positions and reset values for the
// touch status and interrupt block. Assumes byte addressing on the bus.
`ifndef CAP_TOUCH_CONSTS_SVH
`define CAP_TOUCH_CONSTS_SVH

`define OFS_MATRIX_CFG2 8'h38
`define OFS_STATUS 8'h3c
`define OFS_SCLR 8'h40
`define OFS_IEN 8'h44
`define OFS_IDIS 8'h48
`define OFS_IMASK 8'h4c

`define ZERO32 32'h0000_0000
`define MATRIX_CFG2_WMASK 32'hf0ff_0fff
`define IRQ_BITS 32'h0000_0306

`define BIT_DONE 9
`define BIT_READY 8
`define BIT_BLREQ 4
`define BIT_ACTIVE 3
`define BIT_CHANGE 2
`define BIT_CAL 1
`define BIT_EN 0

`define HIST_LEN 5
`define CONSENSUS_OFF 3'h0
`define CX_ZERO 8'h00
`define SYNC_ZERO 12'h000
`define SYNC_MAX 12'hfff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** common/cap_touch_pkg.sv ***
// Types shared by the touch status and interrupt block and its users.
// Assumes the constants header is compiled alongside.
package cap_touch_pkg;

  // Third matrix configuration word, field layout
  typedef struct packed {
    logic comparator_gating_allow;
    logic [2:0] consensus_length;
    logic [3:0] rsvd_hi;
    logic [7:0] sense_cap_discharge_length;
    logic [3:0] rsvd_lo;
    logic [11:0] xline_start_interval;
  } matrix_cfg_two_type;

  // Acquisition events from the sequencer, one-cycle pulses
  typedef struct packed {
    logic start;
    logic complete;
    logic count_avail;
    logic count_taken;
  } acq_events_type;

  // Levels reported by the rest of the touch module
  typedef struct packed {
    logic module_enabled;
    logic burst_len_wait;
    logic auto_active;
    logic auto_calibrating;
  } sense_state_type;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_DISCHARGE,
    ENG_CX_DISCHARGE
  } engine_state_type;

endpackage : cap_touch_pkg

// *** verification/comparator_model.sv ***
// Behavioural analog comparator that sits across a matrix sense electrode.
// Assumes arm marks the start of a discharge and disarm its end, on aclk.
`timescale 1ns/10ps
`default_nettype none

module comparator_model (
  input wire logic aclk, // Module clock
  input wire logic enable, // High: comparator powered
  input wire logic arm, // Pulse: electrode discharge begins
  input wire logic disarm, // Pulse: discharge was ended
  input wire logic [7:0] delay, // Cycles until the threshold is crossed
  output logic level // Comparator output
);
  logic [7:0] cnt = 8'h00;
  logic crossed = 1'b0;
  logic junk = 1'b0;

  // Threshold crossing after a programmable delay; an unpowered output toggles
  // so that nothing can lean on a value it never promised
  always @(posedge aclk)
  begin
    junk <= ~junk;
    if (arm)
      cnt <= delay;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    if (arm || disarm)
      crossed <= 1'b0;
    else if (cnt == 8'h01)
      crossed <= 1'b1;
  end

  assign level = enable ? crossed : junk;
endmodule : comparator_model

`default_nettype wire

// *** verification/cap_touch_status_irq_test.sv ***
// Self-checking bench for the touch status, interrupt and discharge block.
// Assumes the package is compiled first and the comparator model beside it.
`timescale 1ns/10ps
`default_nettype none

module cap_touch_status_irq_test;
  localparam int TICK = 4; // Cycles per prescaler tick
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic prescale_tick = 1'b0, discharge_start = 1'b0, burst_cycle_end = 1'b0;
  logic xline_request = 1'b0, comparator_in, comparator_enable, discharge_done;
  logic cx_discharge, xline_start, irq;
  cap_touch_pkg::acq_events_type acq_events = '0;
  cap_touch_pkg::sense_state_type sense_state = '0;
  logic [7:0] delay = 8'h06;
  int n_mismatch = 0, checks_done = 0, cycles = 0, t0, ticks, starts;

  cap_touch_status_irq #(.ADDR_W(8)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prescale_tick,
    .comparator_in, .discharge_start, .burst_cycle_end, .xline_request, .acq_events,
    .sense_state, .comparator_enable, .discharge_done, .cx_discharge, .xline_start, .irq);

  comparator_model sense_cmp (.aclk, .enable(comparator_enable), .arm(discharge_start),
    .disarm(discharge_done), .delay(delay), .level(comparator_in));

  always #5 aclk = ~aclk;

  // Prescaler tick one cycle in TICK, plus the hang limit
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    prescale_tick <= (cycles % TICK) == 0;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  // Write cycle: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("write response", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  // Read cycle with comparison of data and response code
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(n, s_axi_rdata, exp);
    check("read response", 32'(s_axi_rresp), 32'(er));
  endtask : rchk

  // Matrix discharge: time from start to end must be above lo and at most hi cycles
  task automatic disch(input logic [31:0] cfg, input int lo, input int hi);
    wr(8'h38, cfg, 2'h0);
    @(posedge aclk);
    discharge_start <= 1'b1;
    t0 = cycles;
    @(posedge aclk);
    discharge_start <= 1'b0;
    step(1);
    check("comparators on", 32'(comparator_enable), 32'h0000_0001);
    do @(posedge aclk); while (discharge_done !== 1'b1);
    check("end time", 32'(cycles - t0 > lo && cycles - t0 <= hi), 32'h0000_0001);
  endtask : disch

  initial
  begin
    step(2);
    aresetn <= 1'b1;
    // Reset values, write-only and unmapped places
    rchk("config", 8'h38, 32'h0000_0000, 2'h0);
    rchk("status", 8'h3c, 32'h0000_0000, 2'h0);
    rchk("mask", 8'h4c, 32'h0000_0000, 2'h0);
    rchk("clear reg", 8'h40, 32'h0000_0000, 2'h0);
    rchk("unmapped", 8'h00, 32'h0000_0000, 2'h2);
    wr(8'h00, 32'hffff_ffff, 2'h2);
    wr(8'h38, 32'hffff_ffff, 2'h0);
    rchk("config", 8'h38, 32'hf0ff_0fff, 2'h0);
    s_axi_wstrb <= 4'h1;
    wr(8'h38, 32'h0000_0000, 2'h0);
    s_axi_wstrb <= 4'hf;
    rchk("config", 8'h38, 32'hf0ff_0f00, 2'h0);
    wr(8'h38, 32'h8000_0000, 2'h0);
    step(3);
    check("gated comparators", 32'(comparator_enable), 32'h0000_0000);
    // Status flags from sequencer pulses and module levels
    wr(8'h38, 32'h0000_0000, 2'h0);
    step(1);
    check("ungated comparators", 32'(comparator_enable), 32'h0000_0001);
    sense_state <= 4'hf;
    acq_events <= 4'b0110;
    step(1);
    acq_events <= 4'b0000;
    sense_state.auto_calibrating <= 1'b0;
    step(2);
    rchk("status", 8'h3c, 32'h0000_031f, 2'h0);
    wr(8'h40, 32'h0000_0104, 2'h0);
    rchk("status", 8'h3c, 32'h0000_021b, 2'h0);
    acq_events <= 4'b1000;
    step(1);
    acq_events <= 4'b0000;
    step(2);
    rchk("status", 8'h3c, 32'h0000_001b, 2'h0);
    sense_state <= 4'h0;
    step(2);
    rchk("status", 8'h3c, 32'h0000_0006, 2'h0);
    // Mask set and clear, and the interrupt line
    check("irq off", 32'(irq), 32'h0000_0000);
    wr(8'h44, 32'hffff_ffff, 2'h0);
    rchk("mask", 8'h4c, 32'h0000_0306, 2'h0);
    check("irq on", 32'(irq), 32'h0000_0001);
    wr(8'h48, 32'h0000_0004, 2'h0);
    rchk("mask", 8'h4c, 32'h0000_0302, 2'h0);
    wr(8'h40, 32'h0000_0002, 2'h0);
    step(2);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(8'h44, 32'h0000_0004, 2'h0);
    step(2);
    check("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(8'h48, 32'hffff_ffff, 2'h0);
    step(2);
    check("irq disabled", 32'(irq), 32'h0000_0000);
    wr(8'h40, 32'h0000_0306, 2'h0);
    rchk("status", 8'h3c, 32'h0000_0000, 2'h0);
    // A change arriving in the very cycle its flag is cleared must survive
    fork
      wr(8'h40, 32'h0000_0004, 2'h0);
      begin
        step(2);
        sense_state.auto_active <= 1'b1;
      end
    join
    rchk("status", 8'h3c, 32'h0000_000c, 2'h0);
    // Discharge ends: at once on consensus zero, after three ticks on three
    disch(32'h8000_0000, 6, 16);
    disch(32'h3000_0000, 6 + 2 * TICK, 6 + 6 * TICK + 8);
    // Cx discharge lasts exactly the programmed tick count
    wr(8'h38, 32'h0004_0000, 2'h0);
    @(posedge aclk);
    burst_cycle_end <= 1'b1;
    ticks = 0;
    @(posedge aclk);
    burst_cycle_end <= 1'b0;
    repeat (60)
    begin
      @(posedge aclk);
      if (cx_discharge === 1'b1 && prescale_tick === 1'b1)
        ticks++;
    end
    check("cx ticks", 32'(ticks), 32'h0000_0004);
    check("cx over", 32'(cx_discharge), 32'h0000_0000);
    // Back-to-back X lines are spaced by the interval
    wr(8'h38, 32'h0000_0003, 2'h0);
    @(posedge aclk);
    xline_request <= 1'b1;
    ticks = 0;
    starts = 0;
    repeat (80)
    begin
      @(posedge aclk);
      if (starts == 1 && prescale_tick === 1'b1)
        ticks++;
      xline_request <= (xline_start === 1'b1 && starts == 0);
      if (xline_start === 1'b1)
        starts++;
    end
    check("x starts", 32'(starts), 32'h0000_0002);
    check("x spacing", 32'(ticks >= 2 && ticks <= 4), 32'h0000_0001);
    stop_test();
  end
endmodule : cap_touch_status_irq_test

`default_nettype wire
